// [rtl/ctu_pkg.sv]
// Notes on behaviour
// - accumulator and temp act as byte or word
// - bank pointer, flags, pointers, pc, sp, status
// - low opcode bits pick bank register
// - byte load copies old low byte, sets NZ
// - word load: upper at address, lower next
// - word store: upper at address, lower next
// - temp word store addressed by accumulator
// - extra pointer word access, upper first
// - indexed address is index plus offset byte
// - only marked flags change; status load all
// - swap exchanges accumulator bytes, nothing else
// - byte exchange low only, word exchange all
// - pointer exchanges swap all sixteen bits
// - bit set/clear: direct address, opcode bit number
// - operand bytes follow written operand order
// - listed cycles, one more where fetch, operand and memory cycles already reach the count
// - word load upper byte from data upper
package ctu_pkg;

    // ---------------------------------------------------------------
    // register widths and reset values
    // ---------------------------------------------------------------
    localparam int          CTU_BANK_PTR_W  = 5;
    localparam logic [15:0] CTU_PC_RESET    = 16'h0000;
    localparam logic [15:0] CTU_SP_RESET    = 16'h0000;
    localparam logic [7:0]  CTU_FLAG_RESET  = 8'h00;
    localparam logic [4:0]  CTU_BANK_RESET  = 5'h00;

    // ---------------------------------------------------------------
    // flag bit positions inside condition_flags
    // ---------------------------------------------------------------
    localparam int CTU_FLAG_C = 0;
    localparam int CTU_FLAG_V = 1;
    localparam int CTU_FLAG_Z = 2;
    localparam int CTU_FLAG_N = 3;

    // ---------------------------------------------------------------
    // register file map on the bus (word offsets in bytes)
    // ---------------------------------------------------------------
    localparam logic [7:0] CTU_OFF_CTRL  = 8'h00;
    localparam logic [7:0] CTU_OFF_STAT  = 8'h04;
    localparam logic [7:0] CTU_OFF_ACC   = 8'h08;
    localparam logic [7:0] CTU_OFF_TEMP  = 8'h0C;
    localparam logic [7:0] CTU_OFF_IDX   = 8'h10;
    localparam logic [7:0] CTU_OFF_EXT   = 8'h14;
    localparam logic [7:0] CTU_OFF_SP    = 8'h18;
    localparam logic [7:0] CTU_OFF_PC    = 8'h1C;
    localparam logic [7:0] CTU_OFF_PSW   = 8'h20;
    localparam int         CTU_CTRL_RUN  = 0;

    // ---------------------------------------------------------------
    // sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        CTU_FETCH,
        CTU_OPND,
        CTU_MEM_HI,
        CTU_MEM_LO,
        CTU_HOLD
    } ctu_state_t;

    // memory request carried to the memory port
    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } ctu_mem_req_t;

endpackage

// [rtl/ctu_ahb_regs.sv]
module ctu_ahb_regs
    import ctu_pkg::*;
(
    input  wire logic        sys_clk,    // system clock
    input  wire logic        reset,      // sync reset
    input  wire logic        hsel,       // slave select
    input  wire logic [31:0] haddr,      // address
    input  wire logic [1:0]  htrans,     // transfer type
    input  wire logic        hwrite,     // write
    input  wire logic [2:0]  hsize,      // size
    input  wire logic [31:0] hwdata,     // write data
    input  wire logic        hready,     // bus ready
    output logic      [31:0] hrdata,     // read data
    output logic             hreadyout,  // always ready
    output logic             hresp,      // always okay
    output logic             run_en,     // core run enable
    input  wire logic [31:0] rd_vec [9]  // readable words
);
    logic       wr_pend_q;
    logic [7:0] addr_q;
    logic       run_q;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign run_en    = run_q;

    // capture the address phase
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            wr_pend_q <= 1'b0;
            addr_q    <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend_q <= hsel && htrans[1] && hwrite;
            addr_q    <= haddr[7:0];
        end
    end

    // control word; only the run bit is writable
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            run_q <= 1'b0;
        else if (wr_pend_q && addr_q == CTU_OFF_CTRL)
            run_q <= hwdata[CTU_CTRL_RUN];
    end

    // read data registered at the address phase, unmapped reads zero
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            hrdata <= 32'h0000_0000;
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            if (haddr[7:2] < 6'd9 && haddr[1:0] == 2'b00)
                hrdata <= rd_vec[haddr[5:2]];
            else
                hrdata <= 32'h0000_0000;
        end
    end
endmodule

// [rtl/ctu_bank_regs.sv]
module ctu_bank_regs
    import ctu_pkg::*;
#(
    parameter int BANKS = 32
)
(
    input  wire logic                  sys_clk,  // system clock
    input  wire logic [CTU_BANK_PTR_W-1:0] bank,  // bank select
    input  wire logic [2:0]            sel,      // register in bank
    input  wire logic                  we,       // write strobe
    input  wire logic [7:0]            wdata,    // write data
    output logic      [7:0]            rdata     // read data
);
    initial
    begin
        if (BANKS != (1 << CTU_BANK_PTR_W))
            $error("bank count must match pointer width");
    end

    // banked general registers, eight per bank
    logic [7:0] mem [BANKS*8];

    assign rdata = mem[{bank, sel}];

    always_ff @(posedge sys_clk)
    begin
        if (we)
            mem[{bank, sel}] <= wdata;
    end
endmodule

// [rtl/ctu_core.sv]
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
module ctu_core
    import ctu_pkg::*;
(
    input  wire logic        sys_clk,    // system clock
    input  wire logic        reset,      // sync reset, active high
    input  wire logic        hsel,       // ahb select
    input  wire logic [31:0] haddr,      // ahb address
    input  wire logic [1:0]  htrans,     // ahb transfer type
    input  wire logic        hwrite,     // ahb write
    input  wire logic [2:0]  hsize,      // ahb size
    input  wire logic [31:0] hwdata,     // ahb write data
    input  wire logic        hready,     // ahb ready in
    output logic      [31:0] hrdata,     // ahb read data
    output logic             hreadyout,  // ahb ready out
    output logic             hresp,      // ahb response
    output ctu_pkg::ctu_mem_req_t mem_req, // memory request
    input  wire logic [7:0]  mem_rdata   // memory read data, same cycle
);
    // ---------------------------------------------------------------
    // architectural state
    // ---------------------------------------------------------------
    logic [15:0] acc_q, temp_q, idx_q, ext_q, sp_q, pc_q;
    logic [7:0]  flags_q;                 // condition_flags
    logic [4:0]  bank_q;                  // bank_select_pointer
    logic [7:0]  psw_hi_q;                // upper byte of program_status_word
    logic [7:0]  op_q, opnd1_q, opnd2_q;
    logic [1:0]  opnd_cnt_q;
    logic [15:0] ea_q;
    logic [7:0]  hi_q;
    logic [4:0]  cyc_q;                   // cycles spent in this instruction
    logic [4:0]  cyc_need;
    ctu_state_t  state_q;
    logic        run_en;
    logic [7:0]  bank_rdata;
    logic        bank_we;
    logic [7:0]  bank_wdata;
    logic [31:0] rd_vec [9];
    logic [7:0]  fetch_byte;

    assign fetch_byte = mem_rdata;

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    // instruction length in bytes
    function automatic logic [1:0] op_len(input logic [7:0] op);
        logic [1:0] n;
        n = 2'd1;
        case (op)
            8'h04, 8'h05, 8'h06, 8'h45, 8'h46, 8'hC5, 8'hC6, 8'hD5, 8'hD6: n = 2'd2;
            8'h60, 8'h61, 8'hC4, 8'hD4, 8'hE4, 8'hE5, 8'hE6, 8'hE7, 8'h85, 8'h86: n = 2'd3;
            8'h87: n = 2'd2;
            default:
            begin
                if (op[7:3] == 5'b10001 || op[7:4] == 4'hA)
                    n = 2'd2;
            end
        endcase
        return n;
    endfunction

    // listed cycle count
    function automatic logic [4:0] op_cycles(input logic [7:0] op);
        logic [4:0] c;
        c = 5'd2;
        case (op)
            8'h45, 8'h47, 8'h05, 8'h92, 8'h07, 8'h82, 8'h43: c = 5'd3;
            8'hF5, 8'hF6, 8'hF7, 8'hE4, 8'hE5, 8'hE6, 8'hE7: c = 5'd3;
            8'h46, 8'h61, 8'h06, 8'h60, 8'h85, 8'h87, 8'hD5, 8'hD7: c = 5'd4;
            8'hC5, 8'h93, 8'hC7, 8'h83: c = 5'd4;
            8'h86, 8'hD6, 8'hD4, 8'hC6, 8'hC4: c = 5'd5;
            default:
            begin
                if (op[7:3] == 5'b01001 || op[7:3] == 5'b00001)
                    c = 5'd3;
                else if (op[7:3] == 5'b10001 || op[7:4] == 4'hA)
                    c = 5'd4;
            end
        endcase
        return c;
    endfunction

    // word access opcodes
    function automatic logic is_word(input logic [7:0] op);
        return op inside {8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'h93, 8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'h83};
    endfunction

    function automatic logic is_store(input logic [7:0] op);
        return op inside {8'h45, 8'h46, 8'h47, 8'h61, 8'h82, 8'h83, 8'hD4, 8'hD5, 8'hD6, 8'hD7,
                          8'h85, 8'h86, 8'h87} || op[7:4] == 4'hA;
    endfunction

    function automatic logic has_mem(input logic [7:0] op);
        return is_word(op) || is_store(op) ||
               op inside {8'h05, 8'h06, 8'h07, 8'h60, 8'h92};
    endfunction

    // effective address from operand bytes, first operand is the high byte of ext
    function automatic logic [15:0] eff_addr(input logic [7:0] op, input logic [7:0] b1,
                                             input logic [7:0] b2);
        logic [15:0] a;
        a = {8'h00, b1};                                    // direct page
        case (op)
            8'h06, 8'h46, 8'h86, 8'hC6, 8'hD6: a = idx_q + {8'h00, b1};
            8'h07, 8'h47, 8'h87, 8'hC7, 8'hD7: a = ext_q;
            8'h60, 8'h61, 8'hC4, 8'hD4: a = {b1, b2};
            8'h92, 8'h93, 8'h82, 8'h83: a = acc_q;
            default: a = {8'h00, b1};
        endcase
        return a;
    endfunction

    // ---------------------------------------------------------------
    // register bus and banked registers
    // ---------------------------------------------------------------
    assign rd_vec[0] = {31'h0, run_en};
    assign rd_vec[1] = {16'h0, bank_q, state_q, flags_q};
    assign rd_vec[2] = {16'h0, acc_q};
    assign rd_vec[3] = {16'h0, temp_q};
    assign rd_vec[4] = {16'h0, idx_q};
    assign rd_vec[5] = {16'h0, ext_q};
    assign rd_vec[6] = {16'h0, sp_q};
    assign rd_vec[7] = {16'h0, pc_q};
    assign rd_vec[8] = {16'h0, psw_hi_q, flags_q};

    ctu_ahb_regs u_regs (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .run_en    (run_en),
        .rd_vec    (rd_vec)
    );

    ctu_bank_regs #(.BANKS(32)) u_bank (
        .sys_clk (sys_clk),
        .bank    (bank_q),
        .sel     (op_q[2:0]),
        .we      (bank_we),
        .wdata   (bank_wdata),
        .rdata   (bank_rdata)
    );

    // bank writes: MOV Ri,A and MOV Ri,#d8 in their final cycle
    assign bank_we    = state_q == CTU_HOLD && cyc_q + 5'd1 == cyc_need &&
                        (op_q[7:3] == 5'b01001 || op_q[7:3] == 5'b10001);
    assign bank_wdata = op_q[7] ? opnd1_q : acc_q[7:0];

    // ---------------------------------------------------------------
    // memory port: fetch at pc, data at the effective address
    // ---------------------------------------------------------------
    always_comb
    begin
        mem_req = '0;
        case (state_q)
            CTU_FETCH, CTU_OPND:
            begin
                mem_req.req  = run_en;
                mem_req.addr = pc_q;
            end
            CTU_MEM_HI, CTU_MEM_LO:
            begin
                mem_req.req  = 1'b1;
                mem_req.we   = is_store(op_q);
                mem_req.addr = (state_q == CTU_MEM_LO) ? ea_q + 16'd1 : ea_q;
                if (op_q[7:4] == 4'hA)
                    mem_req.addr = ea_q;
                if (op_q == 8'h83)
                    mem_req.wdata = (state_q == CTU_MEM_LO) ? temp_q[7:0] : temp_q[15:8];
                else if (op_q == 8'h82)
                    mem_req.wdata = temp_q[7:0];
                else if (op_q inside {8'h85, 8'h86, 8'h87})
                    mem_req.wdata = op_q == 8'h87 ? opnd1_q : opnd2_q;
                else if (op_q[7:4] == 4'hA)
                    mem_req.wdata = op_q[3] ? (hi_q | (8'h01 << op_q[2:0]))
                                            : (hi_q & ~(8'h01 << op_q[2:0]));
                else if (is_word(op_q))
                    mem_req.wdata = (state_q == CTU_MEM_LO) ? acc_q[7:0] : acc_q[15:8];
                else
                    mem_req.wdata = acc_q[7:0];
                if (op_q[7:4] == 4'hA && state_q == CTU_MEM_HI)
                    mem_req.we = 1'b0;             // read half of read-modify-write
            end
            default: mem_req = '0;
        endcase
    end

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_q    <= CTU_FETCH;
            pc_q       <= CTU_PC_RESET;
            op_q       <= 8'h00;
            opnd1_q    <= 8'h00;
            opnd2_q    <= 8'h00;
            opnd_cnt_q <= 2'd0;
            ea_q       <= 16'h0000;
            hi_q       <= 8'h00;
            cyc_q      <= 5'd0;
            cyc_need   <= 5'd1;
        end
        else
        begin
            case (state_q)
                CTU_FETCH:
                    if (run_en)
                    begin
                        op_q       <= fetch_byte;
                        pc_q       <= pc_q + 16'd1;
                        cyc_q      <= 5'd1;
                        cyc_need   <= op_cycles(fetch_byte);
                        opnd_cnt_q <= op_len(fetch_byte) - 2'd1;
                        state_q    <= op_len(fetch_byte) > 2'd1 ? CTU_OPND
                                    : has_mem(fetch_byte) ? CTU_MEM_HI : CTU_HOLD;
                    end
                CTU_OPND:
                begin
                    pc_q  <= pc_q + 16'd1;
                    cyc_q <= cyc_q + 5'd1;
                    if (opnd_cnt_q == op_len(op_q) - 2'd1)
                        opnd1_q <= fetch_byte;
                    else
                        opnd2_q <= fetch_byte;
                    opnd_cnt_q <= opnd_cnt_q - 2'd1;
                    if (opnd_cnt_q == 2'd1)
                    begin
                        ea_q    <= eff_addr(op_q, opnd_cnt_q == op_len(op_q) - 2'd1 ? fetch_byte : opnd1_q,
                                            fetch_byte);
                        state_q <= has_mem(op_q) ? CTU_MEM_HI : CTU_HOLD;
                    end
                end
                CTU_MEM_HI:
                begin
                    cyc_q <= cyc_q + 5'd1;
                    hi_q  <= mem_rdata;
                    state_q <= (is_word(op_q) || op_q[7:4] == 4'hA) ? CTU_MEM_LO : CTU_HOLD;
                end
                CTU_MEM_LO:
                begin
                    cyc_q   <= cyc_q + 5'd1;
                    state_q <= CTU_HOLD;
                end
                CTU_HOLD:
                begin
                    cyc_q <= cyc_q + 5'd1;
                    if (cyc_q + 5'd1 >= cyc_need)
                        state_q <= CTU_FETCH;
                end
                default: state_q <= CTU_FETCH;
            endcase
            if (state_q == CTU_FETCH && run_en && has_mem(fetch_byte) && op_len(fetch_byte) == 2'd1)
                ea_q <= eff_addr(fetch_byte, 8'h00, 8'h00);
        end
    end

    // ---------------------------------------------------------------
    // datapath commit on the last cycle of the instruction
    // ---------------------------------------------------------------
    logic        done;
    logic [7:0]  ld_byte;
    logic [15:0] ld_word;
    logic [7:0]  mem_rdata_lo_q;

    assign done    = state_q == CTU_HOLD && cyc_q + 5'd1 >= cyc_need;
    assign ld_byte = op_q == 8'h04 ? opnd1_q : op_q[7:3] == 5'b00001 ? bank_rdata : hi_q;
    assign ld_word = op_q == 8'hE4 ? {opnd1_q, opnd2_q} : {hi_q, mem_rdata_lo_q};

    // lower byte of a word read, kept for the commit cycle
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            mem_rdata_lo_q <= 8'h00;
        else if (state_q == CTU_MEM_LO)
            mem_rdata_lo_q <= mem_rdata;              // lower byte from next address
    end

    // accumulator, temp and pointer updates
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            acc_q    <= 16'h0000;
            temp_q   <= 16'h0000;
            idx_q    <= 16'h0000;
            ext_q    <= 16'h0000;
            sp_q     <= CTU_SP_RESET;
            flags_q  <= CTU_FLAG_RESET;
            bank_q   <= CTU_BANK_RESET;
            psw_hi_q <= 8'h00;
        end
        else if (done)
        begin
            case (op_q)
                8'h04, 8'h05, 8'h06, 8'h07, 8'h60, 8'h92,
                8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F:
                begin
                    temp_q[7:0]        <= acc_q[7:0];
                    acc_q[7:0]         <= ld_byte;
                    flags_q[CTU_FLAG_N] <= ld_byte[7];
                    flags_q[CTU_FLAG_Z] <= ld_byte == 8'h00;
                end
                8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'h93, 8'hE4:
                begin
                    temp_q              <= acc_q;
                    acc_q               <= ld_word;
                    flags_q[CTU_FLAG_N] <= ld_word[15];
                    flags_q[CTU_FLAG_Z] <= ld_word == 16'h0000;
                end
                8'h10: acc_q <= {acc_q[7:0], acc_q[15:8]};
                8'h42:
                begin
                    acc_q[7:0]  <= temp_q[7:0];
                    temp_q[7:0] <= acc_q[7:0];
                end
                8'h43:
                begin
                    acc_q  <= temp_q;
                    temp_q <= acc_q;
                end
                8'hF7: begin acc_q <= ext_q; ext_q <= acc_q; end
                8'hF6: begin acc_q <= idx_q; idx_q <= acc_q; end
                8'hF5: begin acc_q <= sp_q;  sp_q  <= acc_q; end
                8'hE3: ext_q <= acc_q;
                8'hE2: idx_q <= acc_q;
                8'hE1: sp_q  <= acc_q;
                8'hF3: acc_q <= ext_q;
                8'hF2: acc_q <= idx_q;
                8'hF1: acc_q <= sp_q;
                8'hF0: acc_q <= pc_q;
                8'hE5: sp_q  <= {opnd1_q, opnd2_q};
                8'hE6: idx_q <= {opnd1_q, opnd2_q};
                8'hE7: ext_q <= {opnd1_q, opnd2_q};
                8'h70: acc_q <= {bank_q, 3'b000, flags_q};
                8'h71:
                begin
                    bank_q   <= acc_q[15:11];
                    psw_hi_q <= acc_q[15:8];
                    flags_q  <= acc_q[7:0];
                end
                default: acc_q <= acc_q;
            endcase
        end
    end
endmodule

// [tb/ctu_props.sv]
module ctu_props
    import ctu_pkg::*;
(
    input wire logic                  sys_clk,    // clock
    input wire logic                  reset,      // sync reset
    input wire logic                  hsel,       // slave select
    input wire logic [31:0]           haddr,      // address
    input wire logic [1:0]            htrans,     // transfer type
    input wire logic                  hwrite,     // write
    input wire logic [31:0]           hwdata,     // write data
    input wire logic                  hready,     // bus ready
    input wire logic [31:0]           hrdata,     // read data
    input wire logic                  hreadyout,  // ready out
    input wire logic                  hresp,      // response
    input wire ctu_pkg::ctu_mem_req_t mem_req     // memory request
);
    timeunit 1ns;
    timeprecision 1ps;
    // address phases taken by the slave
    wire rd_ap = hsel && htrans[1] && hready && !hwrite;
    wire wr_ap = hsel && htrans[1] && hready && hwrite;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // run bit written on or off, data phase included
    sequence ctrl_on_s;
        wr_ap && haddr == {24'h0, CTU_OFF_CTRL} ##1 hwdata[0];
    endsequence
    sequence ctrl_off_s;
        wr_ap && haddr == {24'h0, CTU_OFF_CTRL} ##1 !hwdata[0];
    endsequence
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_idle_after_reset: assert property ($past(reset) |-> !mem_req.req) else $error("memory busy after reset");
    a_unmapped_zero: assert property (rd_ap && haddr > 32'h20 && haddr < 32'h100 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_hrdata_holds: assert property (!$past(rd_ap) |-> $stable(hrdata)) else $error("hrdata moved");
    a_we_has_req: assert property (mem_req.we |-> mem_req.req) else $error("write without request");
    a_ctrl_start: assert property (ctrl_on_s |-> ##[0:3] mem_req.req) else $error("core did not start");
    a_ctrl_stop: assert property (ctrl_off_s |-> ##[0:24] !mem_req.req) else $error("core did not stop");
endmodule

// [tb/ctu_mem_model.sv]
module ctu_mem_model
    import ctu_pkg::*;
(
    input  wire ctu_pkg::ctu_mem_req_t mem_req,    // request from core
    input  wire logic                  sys_clk,    // clock
    output logic [7:0]                 mem_rdata   // read data, same cycle
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [65536];
    logic [7:0] last_q = 8'h00;
    // idle bus shows the inverted last byte so a stale read never looks valid
    assign mem_rdata = mem_req.req ? mem[mem_req.addr] : ~last_q;
    // plain always: the bench preloads the array between runs
    always @(posedge sys_clk)
    begin
        if (mem_req.req && mem_req.we)
            mem[mem_req.addr] <= mem_req.wdata;
        if (mem_req.req)
            last_q <= mem[mem_req.addr];
    end
endmodule

// [tb/tb_top.sv]
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    import ctu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic         sys_clk = 0, reset = 1, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [31:0]  haddr = 0, hwdata = 0, hrdata, q;
    logic [1:0]   htrans = 0;
    ctu_mem_req_t mem_req;
    logic [7:0]   mem_rdata, hh, ll, r, m60, m61;
    logic [7:0]   prog [20];
    int           seed = 97, n_fail = 0, checks_done = 0;
    // hsize is tied: only whole-word transfers are made
    ctu_core ctu_core_inst (.sys_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .mem_req, .mem_rdata);
    ctu_mem_model ctu_mem_model_inst (.mem_req, .sys_clk, .mem_rdata);
    initial forever #5 sys_clk = ~sys_clk;
    // expected negative and zero flags after a byte load
    function automatic logic [7:0] nz(input logic [7:0] v);
        logic [7:0] f;
        f = CTU_FLAG_RESET;
        f[CTU_FLAG_N] = v[7];
        f[CTU_FLAG_Z] = (v == 8'h00);
        return f;
    endfunction
    task give_verdict;
        $display("checks %0d, failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // bounded wait for hready sampled high at a rising edge
    task wait_ready;
        int n;
        n = 0;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                n_fail++;
                give_verdict;
            end
            @(posedge sys_clk);
        end
    endtask
    // one single transfer: address phase, then data phase; read data lands in q
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_ready;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready;
        q = hrdata;
    endtask
    initial
    begin
        for (int it = 0; it < 3; it++)
        begin
            reset <= 1'b1;
            {hh, ll, r, m60} = $random(seed);
            m61 = 8'($random(seed));
            // first pass is the corner: zero byte load, negative upper byte
            if (it == 0)
                {hh, r} = 16'h8000;
            prog = '{8'hE4, hh, ll, 8'hD5, 8'h40, 8'h10, 8'hC5, 8'h40, 8'h42, 8'h05,
                     8'h50, 8'hAB, 8'h60, 8'hA5, 8'h61, 8'hE6, 8'h00, 8'h30, 8'h46, 8'h12};
            for (int i = 0; i < 256; i++)
                ctu_mem_model_inst.mem[i] = (i < 20) ? prog[i] : 8'h00;
            ctu_mem_model_inst.mem[16'h0050] = r;
            ctu_mem_model_inst.mem[16'h0060] = m60;
            ctu_mem_model_inst.mem[16'h0061] = m61;
            repeat (16) @(posedge sys_clk);
            reset <= 1'b0;
            // program is 40 cycles; the nop run after it keeps clear of data bytes
            ahb(1'b1, CTU_OFF_CTRL, 32'h1);
            repeat (45) @(posedge sys_clk);
            ahb(1'b1, CTU_OFF_CTRL, 32'h0);
            repeat (30) @(posedge sys_clk);
            `CHK("store hi", hh, ctu_mem_model_inst.mem[16'h0040])
            `CHK("store lo", ll, ctu_mem_model_inst.mem[16'h0041])
            ahb(1'b0, CTU_OFF_ACC, 32'h0);
            `CHK("acc", {hh, r}, q[15:0])
            ahb(1'b0, CTU_OFF_TEMP, 32'h0);
            `CHK("temp", {ll, hh}, q[15:0])
            ahb(1'b0, CTU_OFF_STAT, 32'h0);
            `CHK("flags", nz(r), q[7:0])
            ahb(1'b0, CTU_OFF_IDX, 32'h0);
            `CHK("index", 16'h0030, q[15:0])
            `CHK("indexed", r, ctu_mem_model_inst.mem[16'h0042])
            `CHK("bit set", m60 | 8'h08, ctu_mem_model_inst.mem[16'h0060])
            `CHK("bit clear", m61 & 8'hDF, ctu_mem_model_inst.mem[16'h0061])
            // register writes other than run are refused
            ahb(1'b1, CTU_OFF_ACC, 32'hFFFF);
            ahb(1'b0, 8'h40, 32'h0);
            `CHK("unmapped", 32'h0, q)
            ahb(1'b0, CTU_OFF_ACC, 32'h0);
            `CHK("acc kept", {hh, r}, q[15:0])
        end
        give_verdict;
    end
endmodule
bind ctu_core ctu_props ctu_props_inst (.sys_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .mem_req);
